/* pkg/pcd_pkg.sv */
`default_nettype none
package pcd_pkg;

   // ---------------------------------------------------------------
   // Divider settings and their default parameter values
   // ---------------------------------------------------------------
   localparam int   PCD_DIV_DEF    = 2;
   localparam int   PCD_HIGH_DEF   = 1;
   localparam int   PCD_START_DEF  = 0;
   localparam int   PCD_CNT_W_DEF  = 32;

   // ---------------------------------------------------------------
   // Counter landmarks
   // ---------------------------------------------------------------
   localparam int   PCD_PERIOD_FIRST = 1;
   localparam int   PCD_CNT_STEP     = 1;
   localparam logic PCD_OUT_RST      = 1'h0;

   // ---------------------------------------------------------------
   // Pin input synchroniser
   // ---------------------------------------------------------------
   localparam int   PCD_SYNC_STAGES = 3;
   localparam logic PCD_SYNC_RST    = 1'h0;

endpackage : pcd_pkg
`default_nettype wire

/* core/pcd_edge_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module pcd_edge_sync
   import pcd_pkg::*;
#(
   parameter int STAGES = PCD_SYNC_STAGES
) (
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   input  wire logic pin_in,
   output var  logic rise_r
);

   logic [STAGES-1:0] sync_r;
   logic              level_r;
   logic              agree;

   // ---------------------------------------------------------------
   // Synchroniser chain
   // ---------------------------------------------------------------
   // Stage 0 feeds only stage 1; all decisions use the last two.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sync_r <= {STAGES{PCD_SYNC_RST}};
      end else begin
         sync_r <= {sync_r[STAGES-2:0], pin_in};
      end
   end

   assign agree = (sync_r[STAGES-1] == sync_r[STAGES-2]);

   // ---------------------------------------------------------------
   // Filtered level and rising edge
   // ---------------------------------------------------------------
   // A level counts only once the last two stages agree, so a glitch
   // that lives for one sample is dropped rather than counted.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         level_r <= PCD_SYNC_RST;
      end else if (agree) begin
         level_r <= sync_r[STAGES-1];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rise_r <= 1'h0;
      end else begin
         rise_r <= agree && sync_r[STAGES-1] && !level_r;
      end
   end

endmodule : pcd_edge_sync
`default_nettype wire

/* core/pcd_divider.sv */
`timescale 1ns/1ns
`default_nettype none
module pcd_divider
   import pcd_pkg::*;
#(
   parameter int DIV_FACTOR  = PCD_DIV_DEF,
   parameter int HIGH_CYCLES = PCD_HIGH_DEF,
   parameter int START_COUNT = PCD_START_DEF,
   parameter int CNT_W       = PCD_CNT_W_DEF
) (
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   input  wire logic freq_in,
   output var  logic freq_out_r
);

   // ---------------------------------------------------------------
   // Effective settings
   // ---------------------------------------------------------------
   // Ratio and high settings below one are raised to one rather than trusted (the start count is not), so a
   // bad parameter cannot stall the counter or silence the output.
   localparam int DIV_EFF  = (DIV_FACTOR  < 1) ? 1 : DIV_FACTOR;
   localparam int HIGH_EFF = (HIGH_CYCLES < 1) ? 1 : HIGH_CYCLES;

   localparam logic signed [CNT_W-1:0] DIV_C   =
      (CNT_W)'(DIV_EFF);
   localparam logic signed [CNT_W-1:0] HIGH_C  =
      (CNT_W)'(HIGH_EFF);
   localparam logic signed [CNT_W-1:0] START_C =
      (CNT_W)'(START_COUNT);
   localparam logic signed [CNT_W-1:0] FIRST_C =
      (CNT_W)'(PCD_PERIOD_FIRST);
   localparam logic signed [CNT_W-1:0] STEP_C  =
      (CNT_W)'(PCD_CNT_STEP);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic                    edge_pulse;
   logic signed [CNT_W-1:0] cnt_r;
   logic signed [CNT_W-1:0] cnt_nxt;
   logic signed [CNT_W-1:0] cnt_inc;

   // High phase decode
   function automatic logic pcd_in_high(
      input logic signed [CNT_W-1:0] c
   );
      return (c >= FIRST_C) && (c <= HIGH_C);
   endfunction : pcd_in_high

   // Counter values that lie inside one output period
   function automatic logic pcd_in_period(
      input logic signed [CNT_W-1:0] c
   );
      return (c >= FIRST_C) && (c <= DIV_C);
   endfunction : pcd_in_period

   // ---------------------------------------------------------------
   // Input clock edge detection
   // ---------------------------------------------------------------
   // The input clock is sampled, not used as a clock; it must stay
   // well below a quarter of sys_clk for every edge to be seen.
   pcd_edge_sync #(
      .STAGES (PCD_SYNC_STAGES)
   ) u_sync (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .pin_in  (freq_in),
      .rise_r  (edge_pulse)
   );

   // ---------------------------------------------------------------
   // Counter
   // ---------------------------------------------------------------
   assign cnt_inc = cnt_r + STEP_C;

   // Reaching one plus the ratio is folded onto one, so the period
   // restarts without ever holding that value.
   always_comb begin
      if (cnt_inc > DIV_C) begin
         cnt_nxt = FIRST_C;
      end else begin
         cnt_nxt = cnt_inc;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cnt_r <= START_C;
      end else if (edge_pulse) begin
         cnt_r <= cnt_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Output
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         freq_out_r <= PCD_OUT_RST;
      end else if (edge_pulse) begin
         freq_out_r <= pcd_in_high(cnt_nxt);
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   sequence s_edge;
      edge_pulse;
   endsequence

   sequence s_no_edge;
      !edge_pulse;
   endsequence

   sequence s_at_top;
      edge_pulse && (cnt_r == DIV_C);
   endsequence

   sequence s_negative_step;
      edge_pulse && (cnt_r < 0);
   endsequence

   sequence s_enter_high;
      edge_pulse && (cnt_r >= 0) && (cnt_r < HIGH_C);
   endsequence

   sequence s_in_step;
      edge_pulse && (cnt_r >= FIRST_C) && (cnt_r < DIV_C);
   endsequence

   a_hold_between_edges: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      s_no_edge |=> $stable(cnt_r) && $stable(freq_out_r))
      else $error("divider state moved without an input rising edge");

   a_edges_are_pulses: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      s_edge |=> s_no_edge)
      else $error("input edge pulse lasted more than one cycle");

   a_period_wrap: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      s_at_top |=> (cnt_r == FIRST_C) && freq_out_r)
      else $error("counter did not restart the period after the ratio");

   a_high_phase_len: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      s_enter_high |=> freq_out_r)
      else $error("output not high in the configured high phase");

   a_start_load: assert property (
      @(posedge sys_clk)
      $past(sys_rst) && !sys_rst |-> (cnt_r == START_C) && !freq_out_r)
      else $error("counter not loaded with start count after reset");

   a_first_high: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      s_edge and (cnt_r == 0) |=> freq_out_r ##1 freq_out_r)
      else $error("output not high after the edge from count zero");

   a_neg_count_delay: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      s_negative_step |=> !freq_out_r && (cnt_r == $past(cnt_r) + STEP_C))
      else $error("negative count did not step toward one with output low");

   a_low_after_high: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      s_edge and (cnt_r >= HIGH_C) and (cnt_r < DIV_C)
      |=> !freq_out_r && (cnt_r == $past(cnt_r) + STEP_C))
      else $error("output not low in the rest of the period");

   // The pin reaches the edge pulse four samples late, so a pulse
   // always stands on two high samples and never on a fall.
   a_fall_ignored: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      s_edge |-> $past(freq_in, 3) && $past(freq_in, 4))
      else $error("edge pulse raised without a rising input clock");

   // Refilling the filter takes four samples, so counted edges can
   // never come back to back faster than that.
   a_edge_spacing: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      s_edge |=> s_no_edge [*3])
      else $error("two input edges counted closer than the filter allows");

   a_out_edge_only: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      $changed(freq_out_r) |-> $past(edge_pulse))
      else $error("output changed without a counted input edge");

   // Away from the first edge after reset, the output only ever
   // rises on the count that opens a period.
   a_rise_at_one: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      $rose(freq_out_r) |-> (cnt_r == FIRST_C) || ($past(cnt_r) == START_C))
      else $error("output rose away from the start of a period");

   a_low_while_neg: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      (cnt_r <= 0) |-> !freq_out_r)
      else $error("output high while the count is not yet positive");

   a_count_bounded: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      pcd_in_period(cnt_r) |=> pcd_in_period(cnt_r))
      else $error("counter left the period once inside it");

   a_cnt_step: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      s_in_step |=> (cnt_r == $past(cnt_r) + STEP_C))
      else $error("counter did not step by one inside the period");

endmodule : pcd_divider
`default_nettype wire

/* dv/pcd_clk_src.sv */
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// Clock source: one rising edge per request, then low again
// ---------------------------------------------------------------
module pcd_clk_src (
   input  wire logic       sys_clk,
   input  wire logic       rise_req,
   input  wire logic [7:0] hi_len,
   input  wire logic [7:0] lo_len,
   output logic            freq_in,
   output logic            busy
);
   int cnt_r = 0;

   // Line rests low between requests, so no stray edge reaches the divider
   always_ff @(posedge sys_clk) begin
      if (cnt_r == 0 && rise_req) begin
         cnt_r <= int'(hi_len) + int'(lo_len);
      end else if (cnt_r > 0) begin
         cnt_r <= cnt_r - 1;
      end
   end

   assign freq_in = (cnt_r > int'(lo_len));
   assign busy    = (cnt_r != 0);
endmodule : pcd_clk_src
`default_nettype wire

/* dv/programmable_clock_divider_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module programmable_clock_divider_bench
   import pcd_pkg::*;
;
   logic        sys_clk  = 1'b0;
   logic        sys_rst  = 1'b1;
   logic        rise_req = 1'b0;
   logic [7:0]  hi_len   = 8'h03;
   logic [7:0]  lo_len   = 8'h03;
   logic        freq_in;
   logic        busy;
   logic        out_a;
   logic        out_b;
   int          errors   = 0;
   int          n_checks = 0;
   int          cyc      = 0;
   // ---------------------------------------------------------------
   // Rows: bit i is the output expected after rise i+1
   // ---------------------------------------------------------------
   logic [11:0] exp_a    = 12'h555;
   logic [11:0] exp_b    = 12'hCCC;

   initial begin
      forever #10 sys_clk = ~sys_clk;
   end

   pcd_clk_src src (.sys_clk(sys_clk), .rise_req(rise_req),
      .hi_len(hi_len), .lo_len(lo_len), .freq_in(freq_in), .busy(busy));
   pcd_divider uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .freq_in(freq_in), .freq_out_r(out_a));
   // Ratio 4, two high cycles, start two counts back
   pcd_divider #(.DIV_FACTOR(4), .HIGH_CYCLES(2), .START_COUNT(-2)) uut_b
      (.sys_clk(sys_clk), .sys_rst(sys_rst), .freq_in(freq_in),
       .freq_out_r(out_b));

   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test

   task automatic check(input string nm, input logic e, input logic g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %b seen %b", nm, e, g);
      end
   endtask : check

   // Waits for the source to finish, which outlasts the sync latency
   task automatic rise();
      int k;
      @(posedge sys_clk);
      #1 rise_req = 1'b1;
      @(posedge sys_clk);
      #1 rise_req = 1'b0;
      k = 0;
      while (busy === 1'b1 && k < 40) begin
         @(posedge sys_clk);
         #1;
         k++;
      end
      if (k >= 40) errors++;
   endtask : rise

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 1000) begin
         errors++;
         finish_test();
      end
   end

   initial begin
      repeat (3) @(posedge sys_clk);
      #1 sys_rst = 1'b0;
      repeat (4) @(posedge sys_clk);
      for (int i = 0; i < 12; i++) begin
         rise();
         check("out_a", exp_a[i], out_a);
         check("out_b", exp_b[i], out_b);
      end
      $display("table test done");
      // Long high phase: a falling edge must not advance the count
      hi_len = 8'h08;
      lo_len = 8'h08;
      rise();
      check("out_a", 1'b1, out_a);
      check("out_b", 1'b0, out_b);
      rise();
      check("out_a", 1'b0, out_a);
      check("out_b", 1'b0, out_b);
      $display("slow source test done");
      @(posedge sys_clk);
      #1 sys_rst = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      check("out_a", PCD_OUT_RST, out_a);
      check("out_b", PCD_OUT_RST, out_b);
      sys_rst = 1'b0;
      hi_len = 8'h03;
      lo_len = 8'h03;
      repeat (4) @(posedge sys_clk);
      rise();
      check("out_a", 1'b1, out_a);
      check("out_b", 1'b0, out_b);
      rise();
      check("out_b", 1'b0, out_b);
      rise();
      check("out_b", 1'b1, out_b);
      $display("reset restart test done");
      finish_test();
   end
endmodule : programmable_clock_divider_bench
`default_nettype wire
